/* core/elc_top.sv */
/*
 * External link configuration bank: nine link control registers, eight static
 * forwarding registers, an interrupt status/mask pair, on an AHB-Lite slave.
 * Assumes a single master, whole-word single transfers, and link logic on the
 * same clock that reports error and credit state as levels.
 */
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "elc_map.svh"

module elc_top import elc_pkg::*; #(
	parameter int LINKS = 9,
	parameter int STATICS = 8
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// link status from the link logic
	input wire elc_link_stat_type [LINKS-1:0] i_link_stat,
	// link controls
	output elc_link_cfg_type [LINKS-1:0] o_link_cfg,
	output logic [LINKS-1:0] o_pin_to_link,
	output logic [LINKS-1:0] o_credit_clear,
	output logic [LINKS-1:0] o_send_greeting,
	output logic [LINKS-1:0] o_rx_realign,
	// static forwarding, index 0 is link a through index 7 link h
	output elc_static_type [STATICS-1:0] o_static,
	// interrupt
	output logic o_irq
);
	// ------------------------------------------------------------------------
	// bus address phase capture
	// ------------------------------------------------------------------------
	logic wr_pend;
	logic [7:0] wr_idx;
	logic rd_pend;
	logic [7:0] rd_idx;
	logic [LINKS-1:0] err_q;
	logic [LINKS-1:0] irq_status;
	logic [LINKS-1:0] irq_mask;
	logic [LINKS-1:0] next_status;
	logic [31:0] next_rdata;
	logic take;

	assign take = i_hsel && i_hready && i_htrans[1];

	// write data arrives one cycle after the address phase, so keep the index
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_idx <= 8'h00;
			rd_idx <= 8'h00;
		end else if (i_hready) begin
			wr_pend <= take && i_hwrite;
			rd_pend <= take && !i_hwrite;
			wr_idx <= i_haddr[9:2];
			rd_idx <= i_haddr[9:2];
		end
	end

	// zero wait states and always okay; the bank never needs to stall
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// link control registers
	// ------------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < LINKS; gi++) begin : g_link
			logic hit;
			assign hit = wr_pend && (wr_idx == `ELC_IDX_LINK_CONTROL_0 + 8'(gi));
			// configuration fields, reserved bits are simply not stored
			always_ff @(posedge i_sys_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					o_link_cfg[gi].enable <= 1'b0;
					o_link_cfg[gi].wide <= 1'b0;
					o_link_cfg[gi].sym_gap <= `ELC_RST_GAP;
					o_link_cfg[gi].tok_gap <= `ELC_RST_GAP;
					o_pin_to_link[gi] <= 1'b0;
				end else if (hit) begin
					o_link_cfg[gi].enable <= i_hwdata[`ELC_BIT_ENABLE];
					o_pin_to_link[gi] <= i_hwdata[`ELC_BIT_ENABLE];
					o_link_cfg[gi].wide <= i_hwdata[`ELC_BIT_WIDE];
					o_link_cfg[gi].sym_gap <= i_hwdata[`ELC_SYM_GAP_HI:`ELC_SYM_GAP_LO];
					o_link_cfg[gi].tok_gap <= i_hwdata[`ELC_TOK_GAP_HI:`ELC_TOK_GAP_LO];
				end
			end
			// action strobes last one cycle and are never stored for read back
			always_ff @(posedge i_sys_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					o_credit_clear[gi] <= 1'b0;
					o_send_greeting[gi] <= 1'b0;
					o_rx_realign[gi] <= 1'b0;
				end else begin
					o_credit_clear[gi] <= hit && i_hwdata[`ELC_BIT_INIT];
					o_send_greeting[gi] <= hit && i_hwdata[`ELC_BIT_INIT];
					o_rx_realign[gi] <= hit && i_hwdata[`ELC_BIT_RX_RESET];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// static forwarding registers
	// ------------------------------------------------------------------------
	// physical order of the bank: c, d, a, b, g, h, e, f onto link indices
	localparam logic [2:0] STATIC_LINK [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};
	generate
		for (gi = 0; gi < STATICS; gi++) begin : g_static
			logic hit;
			assign hit = wr_pend && (wr_idx == `ELC_IDX_STATIC_C + 8'(gi));
			always_ff @(posedge i_sys_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					o_static[STATIC_LINK[gi]] <= '0;
				end else if (hit) begin
					o_static[STATIC_LINK[gi]].enable <= i_hwdata[`ELC_BIT_STATIC_EN];
					o_static[STATIC_LINK[gi]].dest_core <= i_hwdata[`ELC_BIT_DEST_CORE];
					o_static[STATIC_LINK[gi]].dest_chan <= i_hwdata[`ELC_DEST_CHAN_HI:`ELC_DEST_CHAN_LO];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// interrupts: error flag rising edges latch sticky status bits
	// ------------------------------------------------------------------------
	always_comb begin
		next_status = irq_status;
		if (wr_pend && wr_idx == `ELC_IDX_IRQ_STATUS) begin
			next_status = irq_status & ~i_hwdata[LINKS-1:0];
		end
		// a new error in the clearing cycle still lands
		for (int k = 0; k < LINKS; k++) begin
			if (i_link_stat[k].error && !err_q[k]) begin
				next_status[k] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			err_q <= '0;
			irq_status <= '0;
			irq_mask <= '0;
			o_irq <= 1'b0;
		end else begin
			for (int k = 0; k < LINKS; k++) begin
				err_q[k] <= i_link_stat[k].error;
			end
			irq_status <= next_status;
			if (wr_pend && wr_idx == `ELC_IDX_IRQ_MASK) begin
				irq_mask <= i_hwdata[LINKS-1:0];
			end
			o_irq <= |(next_status & irq_mask);
		end
	end

	// ------------------------------------------------------------------------
	// read mux, registered so hrdata comes from a flip-flop
	// ------------------------------------------------------------------------
	// the data is prepared during the address phase and shown in the data phase
	always_comb begin
		logic [7:0] idx;
		idx = i_haddr[9:2];
		next_rdata = 32'h00000000;
		if (idx >= `ELC_IDX_LINK_CONTROL_0 && idx <= `ELC_IDX_LINK_CONTROL_8) begin
			for (int k = 0; k < LINKS; k++) begin
				if (idx == `ELC_IDX_LINK_CONTROL_0 + 8'(k)) begin
					next_rdata[`ELC_BIT_ENABLE] = o_link_cfg[k].enable;
					next_rdata[`ELC_BIT_WIDE] = o_link_cfg[k].wide;
					next_rdata[`ELC_BIT_ERROR] = i_link_stat[k].error;
					next_rdata[`ELC_BIT_CREDIT_GIVEN] = i_link_stat[k].credit_given;
					next_rdata[`ELC_BIT_CREDIT_HELD] = i_link_stat[k].credit_held;
					next_rdata[`ELC_SYM_GAP_HI:`ELC_SYM_GAP_LO] = o_link_cfg[k].sym_gap;
					next_rdata[`ELC_TOK_GAP_HI:`ELC_TOK_GAP_LO] = o_link_cfg[k].tok_gap;
				end
			end
			// a pipelined write to the same register lands at this very edge, so show its data, not the stale copy
			if (wr_pend && wr_idx == idx) begin
				next_rdata[`ELC_BIT_ENABLE] = i_hwdata[`ELC_BIT_ENABLE];
				next_rdata[`ELC_BIT_WIDE] = i_hwdata[`ELC_BIT_WIDE];
				next_rdata[`ELC_SYM_GAP_HI:`ELC_SYM_GAP_LO] = i_hwdata[`ELC_SYM_GAP_HI:`ELC_SYM_GAP_LO];
				next_rdata[`ELC_TOK_GAP_HI:`ELC_TOK_GAP_LO] = i_hwdata[`ELC_TOK_GAP_HI:`ELC_TOK_GAP_LO];
			end
		end else if (idx >= `ELC_IDX_STATIC_C && idx <= `ELC_IDX_STATIC_F) begin
			for (int k = 0; k < STATICS; k++) begin
				if (idx == `ELC_IDX_STATIC_C + 8'(k)) begin
					next_rdata[`ELC_BIT_STATIC_EN] = o_static[STATIC_LINK[k]].enable;
					next_rdata[`ELC_BIT_DEST_CORE] = o_static[STATIC_LINK[k]].dest_core;
					next_rdata[`ELC_DEST_CHAN_HI:`ELC_DEST_CHAN_LO] = o_static[STATIC_LINK[k]].dest_chan;
				end
			end
			// same forwarding of a write still in its data phase
			if (wr_pend && wr_idx == idx) begin
				next_rdata[`ELC_BIT_STATIC_EN] = i_hwdata[`ELC_BIT_STATIC_EN];
				next_rdata[`ELC_BIT_DEST_CORE] = i_hwdata[`ELC_BIT_DEST_CORE];
				next_rdata[`ELC_DEST_CHAN_HI:`ELC_DEST_CHAN_LO] = i_hwdata[`ELC_DEST_CHAN_HI:`ELC_DEST_CHAN_LO];
			end
		end else if (idx == `ELC_IDX_IRQ_STATUS) begin
			// next value already folds in a pending clear and any new event
			next_rdata[LINKS-1:0] = next_status;
		end else if (idx == `ELC_IDX_IRQ_MASK) begin
			if (wr_pend && wr_idx == idx) begin
				next_rdata[LINKS-1:0] = i_hwdata[LINKS-1:0];
			end else begin
				next_rdata[LINKS-1:0] = irq_mask;
			end
		end else begin
			next_rdata = 32'h00000000;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hrdata <= 32'h00000000;
		end else if (take && !i_hwrite) begin
			o_hrdata <= next_rdata;
		end
	end
	// rd_pend and rd_idx are kept for symmetry of the pipeline only
	logic unused_rd;
	assign unused_rd = rd_pend ^ rd_idx[0] ^ (|i_hsize);
endmodule // elc_top

/* core/elc_map.svh */
/*
 * Register map of the external link configuration bank: offsets, field positions,
 * reset values. Assumes byte addressing over a 32-bit AHB-Lite bus.
 */
`ifndef ELC_MAP_SVH
`define ELC_MAP_SVH
// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define ELC_IDX_LINK_CONTROL_0 8'h80
`define ELC_IDX_LINK_CONTROL_8 8'h88
`define ELC_IDX_STATIC_C 8'ha0
`define ELC_IDX_STATIC_F 8'ha7
`define ELC_IDX_IRQ_STATUS 8'hc0
`define ELC_IDX_IRQ_MASK 8'hc1
// ----------------------------------------------------------------------------
// link control fields
// ----------------------------------------------------------------------------
`define ELC_BIT_ENABLE 31
`define ELC_BIT_WIDE 30
`define ELC_BIT_ERROR 27
`define ELC_BIT_CREDIT_GIVEN 26
`define ELC_BIT_CREDIT_HELD 25
`define ELC_BIT_INIT 24
`define ELC_BIT_RX_RESET 23
`define ELC_SYM_GAP_HI 21
`define ELC_SYM_GAP_LO 11
`define ELC_TOK_GAP_HI 10
`define ELC_TOK_GAP_LO 0
// ----------------------------------------------------------------------------
// static forward fields
// ----------------------------------------------------------------------------
`define ELC_BIT_STATIC_EN 31
`define ELC_BIT_DEST_CORE 8
`define ELC_DEST_CHAN_HI 4
`define ELC_DEST_CHAN_LO 0
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ELC_RST_GAP 11'h000
`define ELC_RST_CHAN 5'h00
`endif

/* core/elc_pkg.sv */
/*
 * Types shared by the external link configuration bank.
 * Assumes the map header supplies offsets and fields.
 */
package elc_pkg;
	// per-link configuration as seen by the link logic
	typedef struct packed {
		logic enable;
		logic wide;
		logic [10:0] sym_gap;
		logic [10:0] tok_gap;
	} elc_link_cfg_type;
	// per-link static forwarding target
	typedef struct packed {
		logic enable;
		logic dest_core;
		logic [4:0] dest_chan;
	} elc_static_type;
	// per-link status reported by the link logic
	typedef struct packed {
		logic error;
		logic credit_given;
		logic credit_held;
	} elc_link_stat_type;
endpackage

/* verif/elc_link_peer.sv */
/*
 * Remote end of the serial links: answers a greeting with credit after a wait.
 * Assumes the bank's greeting and credit-clear pulses are one cycle long.
 */
`timescale 1ns/1ps
module elc_link_peer import elc_pkg::*; #(
	parameter int LINKS = 9
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// pulses from the bank, plus bench controls
	input wire logic [LINKS-1:0] i_credit_clear,
	input wire logic [LINKS-1:0] i_send_greeting,
	input wire logic [3:0] i_delay,
	input wire logic [LINKS-1:0] i_error,
	// status seen by the bank
	output elc_link_stat_type [LINKS-1:0] o_stat
);
	// ------------------------------------------------------------
	// credit handshake
	// ------------------------------------------------------------
	logic [3:0] wait_cnt [LINKS];
	// i_delay above 14 would wrap the counter, so the bench stays below
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_stat <= '0;
			wait_cnt <= '{default: 4'h0};
		end else begin
			for (int k = 0; k < LINKS; k++) begin
				o_stat[k].error <= i_error[k];
				if (i_credit_clear[k]) begin
					o_stat[k].credit_held <= 1'b0;
				end
				if (i_send_greeting[k]) begin
					wait_cnt[k] <= i_delay + 4'h1;
				end else if (wait_cnt[k] != 4'h0) begin
					wait_cnt[k] <= wait_cnt[k] - 4'h1;
					if (wait_cnt[k] == 4'h1) begin
						o_stat[k].credit_held <= 1'b1;
						o_stat[k].credit_given <= 1'b1;
					end
				end
			end
		end
	end
endmodule // elc_link_peer

/* verif/elc_top_checker.sv */
/*
 * Checker for the link configuration bank, watching link 0 and static link a, plus pin mux and pulse pairing on all links.
 * Assumes zero wait states and that hready is the slave's own hreadyout.
 */
`timescale 1ns/1ps
module elc_top_checker import elc_pkg::*; #(
	parameter int LINKS = 9,
	parameter int STATICS = 8
) (
	// clock, reset and bus
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	// link side
	input wire elc_link_stat_type [LINKS-1:0] i_link_stat,
	input wire elc_link_cfg_type [LINKS-1:0] o_link_cfg,
	input wire logic [LINKS-1:0] o_pin_to_link,
	input wire logic [LINKS-1:0] o_credit_clear,
	input wire logic [LINKS-1:0] o_send_greeting,
	input wire logic [LINKS-1:0] o_rx_realign,
	input wire elc_static_type [STATICS-1:0] o_static
);
	// ------------------------------------------------------------
	// data phase tracking
	// ------------------------------------------------------------
	logic wr_pend;
	logic rd_pend;
	logic [7:0] idx;
	logic [LINKS-1:0] en_v;
	// remember the address phase so the data phase can be judged
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			idx <= 8'h00;
		end else if (i_hready) begin
			wr_pend <= i_hsel & i_htrans[1] & i_hwrite;
			rd_pend <= i_hsel & i_htrans[1] & ~i_hwrite;
			idx <= i_haddr[9:2];
		end
	end
	// gather the enable bits for the pin mux comparison
	always_comb begin
		for (int k = 0; k < LINKS; k++) begin
			en_v[k] = o_link_cfg[k].enable;
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	property p_mux;
		o_pin_to_link == en_v;
	endproperty
	a_mux: assert property (p_mux) else $error("pin mux differs from enable");
	property p_pair;
		o_credit_clear == o_send_greeting;
	endproperty
	a_pair: assert property (p_pair) else $error("credit clear without greeting");
	property p_ctl;
		wr_pend && idx == 8'h80 |=> o_link_cfg[0].enable == $past(i_hwdata[31]) && o_link_cfg[0].wide == $past(i_hwdata[30]);
	endproperty
	a_ctl: assert property (p_ctl) else $error("enable or width not written");
	property p_gap;
		wr_pend && idx == 8'h80 |=> {o_link_cfg[0].sym_gap, o_link_cfg[0].tok_gap} == $past(i_hwdata[21:0]);
	endproperty
	a_gap: assert property (p_gap) else $error("gap fields not written");
	property p_act;
		wr_pend && idx == 8'h80 |=> o_send_greeting[0] == $past(i_hwdata[24]) && o_rx_realign[0] == $past(i_hwdata[23]);
	endproperty
	a_act: assert property (p_act) else $error("action pulse wrong");
	property p_stat;
		wr_pend && idx == 8'ha2 |=> o_static[0] == $past({i_hwdata[31], i_hwdata[8], i_hwdata[4:0]});
	endproperty
	a_stat: assert property (p_stat) else $error("static link a wrong");
	property p_rd;
		rd_pend && idx == 8'h80 |-> o_hrdata[27:25] == $past(i_link_stat[0]);
	endproperty
	a_rd: assert property (p_rd) else $error("status bits read wrong");
	property p_rsv;
		rd_pend && (idx == 8'h80 || idx == 8'ha2) |-> (o_hrdata & (idx == 8'h80 ? 32'h31c00000 : 32'h7ffffee0)) == 32'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
endmodule // elc_top_checker
bind elc_top elc_top_checker #(.LINKS(LINKS), .STATICS(STATICS)) u_checker (.i_sys_clk, .i_resetn, .i_hsel,
	.i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .i_link_stat, .o_link_cfg, .o_pin_to_link,
	.o_credit_clear, .o_send_greeting, .o_rx_realign, .o_static);

/* verif/tb.sv */
/*
 * Testbench for the link configuration bank: AHB-Lite tasks and register checks.
 * Assumes the remote-end model feeds link status and the checker is bound in.
 */
`timescale 1ns/1ps
module tb import elc_pkg::*;;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] delay = 4'h0;
	logic [8:0] err_in = 9'h0;
	logic [31:0] hrdata;
	logic [31:0] v;
	logic hready;
	logic hresp;
	logic irq;
	logic [8:0] pins;
	logic [8:0] cclr;
	logic [8:0] greet;
	elc_link_stat_type [8:0] stat;
	elc_link_cfg_type [8:0] cfg;
	elc_static_type [7:0] stc;
	int error_cnt = 0;
	int n_tests = 0;
	int map [8] = '{2, 3, 0, 1, 6, 7, 4, 5};
	elc_top dut (.i_sys_clk, .i_resetn, .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_link_stat(stat), .o_link_cfg(cfg), .o_pin_to_link(pins), .o_credit_clear(cclr),
		.o_send_greeting(greet), .o_rx_realign(), .o_static(stc), .o_irq(irq));
	elc_link_peer peer (.i_sys_clk, .i_resetn, .i_credit_clear(cclr), .i_send_greeting(greet), .i_delay(delay),
		.i_error(err_in), .o_stat(stat));
	always #2.5 i_sys_clk = ~i_sys_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// single transfer; the wait loops lean on the watchdog if hready sticks low
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge i_sys_clk);
		while (hready !== 1'b1) @(posedge i_sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge i_sys_clk);
		while (hready !== 1'b1) @(posedge i_sys_clk);
		v = hrdata;
		check(32'(hresp), 32'h0);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		check(v, exp);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// main sequence; idle cycles let written values settle before direct checks
	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		@(posedge i_sys_clk);
		rd(32'h200, 32'h0);
		rd(32'h280, 32'h0);
		for (int k = 0; k < 9; k++) ahb(1'b1, 32'h200 + 32'(4 * k), 32'hffffffff);
		repeat (8) @(posedge i_sys_clk);
		check(32'(pins), 32'h1ff);
		for (int k = 0; k < 9; k++) begin
			check(32'(cfg[k]), 32'hffffff);
			rd(32'h200 + 32'(4 * k), 32'hc63fffff);
		end
		delay <= 4'he;
		ahb(1'b1, 32'h200, 32'h0);
		@(posedge i_sys_clk);
		check(32'(pins[0]), 32'h0);
		ahb(1'b1, 32'h200, 32'h01000000);
		@(posedge i_sys_clk);
		rd(32'h200, 32'h04000000);
		repeat (20) @(posedge i_sys_clk);
		rd(32'h200, 32'h06000000);
		for (int j = 0; j < 8; j++) begin
			ahb(1'b1, 32'h280 + 32'(4 * j), 32'hfffffee0 | {23'h0, j[0], 3'h0, j[4:0]});
			rd(32'h280 + 32'(4 * j), 32'h80000000 | {23'h0, j[0], 3'h0, j[4:0]});
			check(32'(stc[map[j]]), {25'h0, 1'b1, j[0], j[4:0]});
		end
		ahb(1'b1, 32'h3fc, 32'hffffffff);
		rd(32'h3fc, 32'h0);
		ahb(1'b1, 32'h304, 32'h1);
		err_in <= 9'h003;
		repeat (4) @(posedge i_sys_clk);
		check(32'(irq), 32'h1);
		rd(32'h200, 32'h0e000000);
		rd(32'h300, 32'h3);
		ahb(1'b1, 32'h300, 32'h1);
		repeat (2) @(posedge i_sys_clk);
		check(32'(irq), 32'h0);
		rd(32'h300, 32'h2);
		ahb(1'b1, 32'h304, 32'h2);
		repeat (2) @(posedge i_sys_clk);
		check(32'(irq), 32'h1);
		err_in <= 9'h0;
		tally_and_finish();
	end
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_sys_clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule // tb
